// >>> logic/eldm_pkg.sv
// constants for the encoder latch and deviation monitor
package eldm_pkg;
  localparam logic [7:0] IDX_STATUS = 8'h66;
  localparam logic [7:0] IDX_LATCH = 8'h67;
  localparam logic [7:0] IDX_DEV_LIMIT = 8'h68;
  localparam logic [7:0] IDX_VSTOP_L = 8'h69;
  localparam logic [7:0] IDX_INT_EN = 8'h70;
  localparam logic [7:0] IDX_INT_CLR = 8'h71;
  localparam logic [7:0] IDX_CTRL = 8'h72;
  localparam int ADDR_LSB = 2;
  localparam int IDX_W = 8;
  localparam int LIMIT_W = 20;
  localparam int STAT_W = 2;
  localparam int BIT_INDEX = 0;
  localparam int BIT_WARN = 1;
  localparam int BIT_BEMF = 0;
  localparam logic [31:0] RST_WORD = 32'h0;
  localparam logic [19:0] RST_LIMIT = 20'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> logic/eldm_dev_if.sv
// signals between the register side and the deviation comparator
`timescale 1ns/1ps
`default_nettype none
interface eldm_dev_if;
  logic [31:0] enc_pos;
  logic [31:0] act_pos;
  logic bemf;
  logic [19:0] limit;
  logic exceed;
  modport mon (input enc_pos, input act_pos, input bemf, input limit, output exceed);
  modport ctl (output enc_pos, output act_pos, output bemf, output limit, input exceed);
endinterface
`default_nettype wire

// >>> logic/eldm_dev_mon.sv
// deviation comparator between encoder count and reference position
`timescale 1ns/1ps
`default_nettype none
module eldm_dev_mon (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // comparator signals
  eldm_dev_if.mon dev
);
  logic [32:0] diff;
  logic [32:0] mag;
  logic next_exceed;
  logic exceed;

  always_comb begin
    diff = {dev.enc_pos[31], dev.enc_pos} -
           (dev.bemf ? 33'h0 : {dev.act_pos[31], dev.act_pos});
    mag = diff[32] ? (33'h0 - diff) : diff;
    // zero limit means off, not "any difference warns"
    next_exceed = (dev.limit != eldm_pkg::RST_LIMIT) && (mag > {13'h0, dev.limit});
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exceed <= 1'b0;
    end else begin
      exceed <= next_exceed;
    end
  end

  assign dev.exceed = exceed;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_zero_limit_off: assert property (dev.limit == 20'h0 |=> !exceed)
    else $error("deviation flagged with zero limit");
  chk_bemf_zero_ref: assert property (dev.bemf && dev.enc_pos == 32'h0 |=> !exceed)
    else $error("bemf mode did not compare against zero");
  chk_neg_magnitude: assert property (!dev.bemf && dev.limit != 20'h0 &&
      (dev.act_pos - dev.enc_pos) == {12'h0, dev.limit} + 32'h1 |=> exceed)
    else $error("negative deviation beyond limit not flagged");
  // full-width gap, so a wrapped 32-bit difference is not taken as a small one
  chk_at_limit_ok: assert property (!dev.bemf &&
      ({dev.enc_pos[31], dev.enc_pos} - {dev.act_pos[31], dev.act_pos}) == {13'h0, dev.limit}
      |=> !exceed)
    else $error("deviation equal to limit flagged");
endmodule
`default_nettype wire

// >>> logic/eldm_top.sv
// encoder index latch and deviation monitor with axi4-lite registers
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module eldm_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // encoder side
  input wire logic [31:0] enc_position,
  input wire logic [31:0] internal_actual_position,
  input wire logic index_event,
  // axi4-lite write
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt
  output logic irq
);
  function automatic logic [31:0] byte_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  eldm_dev_if dev();

  // bus state
  logic [7:0] wr_idx, next_wr_idx;
  logic [31:0] wr_data, next_wr_data;
  logic [31:0] wr_mask, next_wr_mask;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic wr_do;
  logic [7:0] rd_idx;
  // register state
  logic [1:0] status, next_status;
  logic [1:0] int_en, next_int_en;
  logic [1:0] clr;
  logic [31:0] latch, next_latch;
  logic [19:0] limit, next_limit;
  logic [31:0] vstop, next_vstop;
  logic bemf, next_bemf;
  logic next_irq;

  assign dev.enc_pos = enc_position;
  assign dev.act_pos = internal_actual_position;
  assign dev.bemf = bemf;
  assign dev.limit = limit;

  eldm_dev_mon u_mon (
    .aclk(aclk),
    .aresetn(aresetn),
    .dev(dev)
  );

  // write executes once both address and data are held
  assign wr_do = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign rd_idx = s_axi_araddr[eldm_pkg::ADDR_LSB +: eldm_pkg::IDX_W];

  always_comb begin
    next_awready = s_axi_awready;
    next_wready = s_axi_wready;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_wr_idx = wr_idx;
    next_wr_data = wr_data;
    next_wr_mask = wr_mask;
    if (s_axi_awvalid && s_axi_awready) begin
      next_wr_idx = s_axi_awaddr[eldm_pkg::ADDR_LSB +: eldm_pkg::IDX_W];
      next_awready = 1'b0;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wr_data = s_axi_wdata;
      next_wr_mask = byte_mask(s_axi_wstrb);
      next_wready = 1'b0;
    end
    if (wr_do) begin
      next_bvalid = 1'b1;
      case (wr_idx)
        eldm_pkg::IDX_STATUS, eldm_pkg::IDX_DEV_LIMIT, eldm_pkg::IDX_VSTOP_L,
        eldm_pkg::IDX_INT_EN, eldm_pkg::IDX_INT_CLR, eldm_pkg::IDX_CTRL: begin
          next_bresp = eldm_pkg::RESP_OKAY;
        end
        default: begin
          // latch is read only, so writes to it are refused too
          next_bresp = eldm_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
      next_awready = 1'b1;
      next_wready = 1'b1;
    end
  end

  always_comb begin
    next_arready = s_axi_arready;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = eldm_pkg::RESP_OKAY;
      case (rd_idx)
        eldm_pkg::IDX_STATUS: next_rdata = {30'h0, status};
        eldm_pkg::IDX_LATCH: next_rdata = latch;
        eldm_pkg::IDX_DEV_LIMIT: next_rdata = {12'h0, limit};
        eldm_pkg::IDX_VSTOP_L: next_rdata = vstop;
        eldm_pkg::IDX_INT_EN: next_rdata = {30'h0, int_en};
        eldm_pkg::IDX_INT_CLR: next_rdata = eldm_pkg::RST_WORD;
        eldm_pkg::IDX_CTRL: next_rdata = {31'h0, bemf};
        default: begin
          next_rdata = eldm_pkg::RST_WORD;
          next_rresp = eldm_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_comb begin
    next_latch = latch;
    next_limit = limit;
    next_vstop = vstop;
    next_int_en = int_en;
    next_bemf = bemf;
    clr = 2'h0;
    if (index_event) begin
      next_latch = enc_position;
    end
    if (wr_do) begin
      case (wr_idx)
        eldm_pkg::IDX_STATUS, eldm_pkg::IDX_INT_CLR: clr = wr_data[1:0] & wr_mask[1:0];
        eldm_pkg::IDX_DEV_LIMIT: begin
          next_limit = (limit & ~wr_mask[19:0]) | (wr_data[19:0] & wr_mask[19:0]);
        end
        eldm_pkg::IDX_VSTOP_L: next_vstop = (vstop & ~wr_mask) | (wr_data & wr_mask);
        eldm_pkg::IDX_INT_EN: begin
          next_int_en = (int_en & ~wr_mask[1:0]) | (wr_data[1:0] & wr_mask[1:0]);
        end
        eldm_pkg::IDX_CTRL: begin
          if (wr_mask[eldm_pkg::BIT_BEMF]) begin
            next_bemf = wr_data[eldm_pkg::BIT_BEMF];
          end
        end
        default: begin
          clr = 2'h0;
        end
      endcase
    end
    // a set arriving with the clear wins, so no event is lost
    next_status[eldm_pkg::BIT_INDEX] = index_event ||
      (status[eldm_pkg::BIT_INDEX] && !clr[eldm_pkg::BIT_INDEX]);
    next_status[eldm_pkg::BIT_WARN] = dev.exceed ||
      (status[eldm_pkg::BIT_WARN] && !clr[eldm_pkg::BIT_WARN]);
    next_irq = |(next_status & next_int_en);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
      wr_idx <= 8'h0;
      wr_data <= 32'h0;
      wr_mask <= 32'h0;
      status <= 2'h0;
      int_en <= 2'h0;
      latch <= eldm_pkg::RST_WORD;
      limit <= eldm_pkg::RST_LIMIT;
      vstop <= eldm_pkg::RST_WORD;
      bemf <= 1'b0;
      irq <= 1'b0;
    end else begin
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      wr_idx <= next_wr_idx;
      wr_data <= next_wr_data;
      wr_mask <= next_wr_mask;
      status <= next_status;
      int_en <= next_int_en;
      latch <= next_latch;
      limit <= next_limit;
      vstop <= next_vstop;
      bemf <= next_bemf;
      irq <= next_irq;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_latch_read;
    s_ar_taken and (rd_idx == eldm_pkg::IDX_LATCH && !index_event);
  endsequence

  chk_latch_capture: assert property (index_event |=> latch == $past(enc_position))
    else $error("index event did not latch encoder position");
  chk_latch_readout: assert property (s_latch_read |=> s_axi_rvalid && s_axi_rdata == latch)
    else $error("latch readout wrong");
  chk_index_flag: assert property (index_event |=> status[0])
    else $error("index event flag not set");
  chk_warn_set: assert property (dev.exceed |=> status[1] ##1 (status[1] || !$past(dev.exceed, 1)))
    else $error("deviation warning not set");
  chk_warn_persist: assert property (dev.exceed && wr_do && clr[1] |=> status[1])
    else $error("warning cleared while deviation persists");
  chk_index_clear: assert property (status[0] && !index_event && wr_do && clr[0] |=> !status[0])
    else $error("index flag not cleared by write one");
  chk_limit_hold: assert property (!wr_do |=> limit == $past(limit))
    else $error("limit changed without a write");
  chk_irq_level: assert property (irq == |(status & int_en))
    else $error("interrupt level mismatch");
endmodule
`default_nettype wire

// >>> sim/eldm_enc_model.sv
// registered encoder position, actual position and index stand-in for the bench
`timescale 1ns/1ps
`default_nettype none
module eldm_enc_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bench requests
  input wire logic [31:0] set_enc,
  input wire logic [31:0] set_act,
  input wire logic idx_req,
  // toward the block
  output logic [31:0] enc_position,
  output logic [31:0] internal_actual_position,
  output logic index_event
);
  // registered so every change lands just after an edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enc_position <= 32'h0;
      internal_actual_position <= 32'h0;
      index_event <= 1'b0;
    end else begin
      enc_position <= set_enc;
      internal_actual_position <= set_act;
      index_event <= idx_req;
    end
  end
endmodule
`default_nettype wire

// >>> sim/encoder_latch_deviation_monitor_bench.sv
// self-checking bench for the encoder latch and deviation monitor
`timescale 1ns/1ps
`default_nettype none
module encoder_latch_deviation_monitor_bench;
  localparam logic [7:0] ST = eldm_pkg::IDX_STATUS;
  localparam logic [7:0] LA = eldm_pkg::IDX_LATCH;
  localparam logic [7:0] LI = eldm_pkg::IDX_DEV_LIMIT;
  localparam logic [7:0] EN = eldm_pkg::IDX_INT_EN;
  localparam logic [1:0] OK = eldm_pkg::RESP_OKAY;
  localparam logic [1:0] SE = eldm_pkg::RESP_SLVERR;
  logic aclk, aresetn, idx_req, index_event, irq;
  logic [31:0] set_enc, set_act, enc_position, internal_actual_position;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] e, a, lim;
  int err_count, num_checks, exp_st, exp_en, exp_lim, exp_bemf, i;
  eldm_enc_model partner (.aclk(aclk), .aresetn(aresetn), .set_enc(set_enc), .set_act(set_act),
    .idx_req(idx_req), .enc_position(enc_position),
    .internal_actual_position(internal_actual_position), .index_event(index_event));
  eldm_top DUT (.aclk(aclk), .aresetn(aresetn), .enc_position(enc_position),
    .internal_actual_position(internal_actual_position), .index_event(index_event),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stall();
    err_count++;
    $display("FAIL handshake expected answer seen none");
    report_and_stop();
  endtask
  task automatic wr(input logic [7:0] x, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= {22'h0, x, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 64) stall();
    s_axi_bready <= 1'b0;
    chk($sformatf("bresp %h", x), {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic rd(input logic [7:0] x, input logic [31:0] exp, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= {22'h0, x, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 64) stall();
    s_axi_rready <= 1'b0;
    chk($sformatf("rresp %h", x), {30'h0, er}, {30'h0, s_axi_rresp});
    chk($sformatf("rdata %h", x), exp, s_axi_rdata);
  endtask
  // deviation as the bench sees it: magnitude of the signed gap
  function automatic bit over();
    longint d;
    d = longint'($signed(set_enc)) - (exp_bemf != 0 ? 0 : longint'($signed(set_act)));
    if (d < 0) d = -d;
    return exp_lim != 0 && d > exp_lim;
  endfunction
  task automatic pos(input logic [31:0] pe, input logic [31:0] pa);
    @(posedge aclk);
    set_enc <= pe;
    set_act <= pa;
    repeat (5) @(posedge aclk);
    if (over()) exp_st |= 2;
    rd(ST, exp_st, OK);
    chk("irq", {31'h0, (exp_st & exp_en) != 0}, {31'h0, irq});
  endtask
  task automatic clr(input logic [7:0] x, input int m);
    wr(x, m, OK);
    exp_st &= ~m;
    if (over()) exp_st |= 2;
    rd(ST, exp_st, OK);
  endtask
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    {aresetn, idx_req, set_enc, set_act, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    {err_count, num_checks, exp_st, exp_en, exp_lim, exp_bemf} = '0;
    void'($urandom(32'hddb63594));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 'h66; i <= 'h72; i++) rd(i[7:0], 32'h0, (i > 'h69 && i < 'h70) ? SE : OK);
    $display("reset and map test done");
    lim = $urandom;
    wr(LI, lim, OK);
    rd(LI, lim & 32'hfffff, OK);
    wr(8'h69, ~lim, OK);
    rd(8'h69, ~lim, OK);
    s_axi_wstrb <= 4'h1;
    wr(8'h69, lim, OK);
    rd(8'h69, (~lim & 32'hffffff00) | (lim & 32'hff), OK);
    s_axi_wstrb <= 4'hf;
    wr(LA, lim, SE);
    rd(LA, 32'h0, OK);
    wr(8'h6b, lim, SE);
    wr(8'h71, 32'h3, OK);
    rd(8'h71, 32'h0, OK);
    wr(EN, 32'hffffffff, OK);
    exp_en = 3;
    rd(EN, 32'h3, OK);
    wr(LI, 32'h0, OK);
    $display("register test done");
    for (i = 0; i < 3; i++) begin
      e = $urandom;
      @(posedge aclk);
      set_enc <= e;
      idx_req <= 1'b1;
      @(posedge aclk);
      idx_req <= 1'b0;
      exp_st |= 1;
      rd(LA, e, OK);
      pos(e, 32'h0);
    end
    wr(EN, 32'h2, OK);
    exp_en = 2;
    pos(e, 32'h0);
    clr(8'h71, 1);
    wr(EN, 32'h3, OK);
    exp_en = 3;
    $display("index test done");
    lim = ($urandom & 32'hffffe) | 32'h2;
    exp_lim = lim;
    a = $urandom & 32'h3fffffff;
    // equal positions first, so arming the limit sees no stale gap
    pos(a, a);
    wr(LI, lim, OK);
    pos(a + lim, a);
    pos(a - lim, a);
    pos(a - lim - 1, a);
    clr(ST, 2);
    pos(a + lim + 1, a);
    pos(a, a);
    clr(ST, 2);
    pos(32'h0, 32'h0);
    wr(eldm_pkg::IDX_CTRL, 32'h1, OK);
    rd(eldm_pkg::IDX_CTRL, 32'h1, OK);
    exp_bemf = 1;
    pos(-lim, a);
    pos(lim + 1, 32'h0);
    pos(32'h0, 32'h7fffffff);
    clr(ST, 2);
    // limit off before leaving back-emf mode, else the old gap would warn
    wr(LI, 32'h0, OK);
    exp_lim = 0;
    wr(eldm_pkg::IDX_CTRL, 32'h0, OK);
    exp_bemf = 0;
    pos(32'h7fff0000, 32'h0);
    $display("deviation test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
